// ===== hw/radio_key_control.sv
// Alarm masking, data-port frame settings, receive buffering, keying and CTS timing.
// Assumes Avalon-MM master on clk, radio data and event word from clk-domain logic,
// and RTS and push-to-talk from external pins.
// Notes on behaviour
// - A 32-bit mask; masked-in events are major alarms driving the alarm output.
// - The mask resets to all ones so every event raises the alarm.
// - A zero mask bit suppresses alarm signalling for that event.
// - Mask bit positions equal the event status word bit positions.
// - Events 25, 26 and 31 are six-volt, input power and temperature faults.
// - Alarm output polarity is selectable active high or active low.
// - Only rates 110 to 38400 from the fixed list of eight are supported.
// - Frame is 7 or 8 data bits, none/odd/even parity, 1 or 2 stops.
// - Frames 7N1, 8O2 and 8E2 are rejected and old setting kept.
// - Reset frame setting is 19200 bits per second, 8N1.
// - Frame settings touch only the main data port, never the diagnostic port.
// - Buffering off: bytes leave as soon as they arrive, gaps allowed.
// - Buffering on (default): bytes held until a threshold or an idle spell, then sent gapless.
// - Buffering changes only received-data timing, not transmit handling.
// - Continuous keying holds the transmitter keyed regardless of other sources.
// - Clear-to-send delay is 0 to 255 ms in 1 ms steps.
// - Terminal mode: CTS rises the programmed delay after RTS rises.
// - Terminal mode, zero delay: key and CTS right after RTS rises.
// - Keyline mode: data held for the delay after CTS; zero adds no wait.
// - RTS keys the transmitter regardless of key-on-character.
// - Key-on-character keys the transmitter once a full character arrives.
// - Without key-on-character only RTS, push-to-talk, continuous or manual key.
// - Keyline mode ignores RTS and drives CTS as a keyline.
// - Keyline mode raises CTS on radio data and holds data until delay ends.
module radio_key_control #(
  parameter int DEPTH         = 16,
  parameter int THRESHOLD     = 8,
  parameter int CYCLES_PER_MS = radio_key_pkg::CYCLES_PER_MS
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [31:0] event_status,
  input  wire logic        rts_pin,
  input  wire logic        push_to_talk_input,
  input  wire logic        char_received,
  input  wire logic        radio_valid,
  input  wire logic [7:0]  radio_data,
  output logic             radio_ready,
  output logic             port_valid,
  output logic      [7:0]  port_data,
  input  wire logic        port_ready,
  output logic             cts,
  output logic             tx_key,
  output logic             alarm_out,
  output logic      [2:0]  port_rate_code,
  output logic             port_eight_bits,
  output logic      [1:0]  port_parity,
  output logic             port_two_stop,
  output logic      [16:0] port_bit_cycles
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int AW = $clog2(DEPTH);

  // Bit period in clock cycles for a rate code
  function automatic logic [16:0] bit_cycles(input logic [2:0] code);
    int rate;
    case (code)
      3'h0: rate = radio_key_pkg::RATE_0;
      3'h1: rate = radio_key_pkg::RATE_1;
      3'h2: rate = radio_key_pkg::RATE_2;
      3'h3: rate = radio_key_pkg::RATE_3;
      3'h4: rate = radio_key_pkg::RATE_4;
      3'h5: rate = radio_key_pkg::RATE_5;
      3'h6: rate = radio_key_pkg::RATE_6;
      default: rate = radio_key_pkg::RATE_7;
    endcase
    return 17'(radio_key_pkg::CLOCK_HZ / rate);
  endfunction

  // Milliseconds to clock cycles
  function automatic logic [23:0] ms_cycles(input logic [7:0] ms);
    return 24'(ms * CYCLES_PER_MS);
  endfunction

  // Reset release through two flip-flops
  logic rst_meta, rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {rst_meta, rst_n} <= 2'b00;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Pin synchronisers
  logic rts_meta, rts_s, ptt_meta, ptt_s, rts_prev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {rts_meta, rts_s, ptt_meta, ptt_s, rts_prev} <= 5'h0;
    end else begin
      rts_meta <= rts_pin;
      rts_s    <= rts_meta;
      ptt_meta <= push_to_talk_input;
      ptt_s    <= ptt_meta;
      rts_prev <= rts_s;
    end
  end

  // Registers
  logic [31:0] alarm_event_mask;
  logic [5:0]  control;
  logic [6:0]  frame;
  logic [7:0]  cts_delay;
  logic        frame_reject;

  wire alarm_output_polarity = control[radio_key_pkg::CTL_POLARITY_HIGH];
  wire receive_buffering     = control[radio_key_pkg::CTL_BUFFERING];
  wire continuous_keying     = control[radio_key_pkg::CTL_CONT_KEY];
  wire key_on_character      = control[radio_key_pkg::CTL_KEY_ON_CHAR];
  wire keyline_mode          = control[radio_key_pkg::CTL_KEYLINE_MODE];
  wire manual_key            = control[radio_key_pkg::CTL_MANUAL_KEY];

  // Bus decode; a transfer completes at the edge where waitrequest is low
  wire        wr_done  = write & ~waitrequest;
  wire        sel_mask = address == radio_key_pkg::OFF_ALARM_MASK;
  wire        sel_ctl  = address == radio_key_pkg::OFF_CONTROL;
  wire        sel_frm  = address == radio_key_pkg::OFF_FRAME;
  wire        sel_cts  = address == radio_key_pkg::OFF_CTS_DELAY;
  wire        sel_sts  = address == radio_key_pkg::OFF_STATUS;
  wire        sel_evt  = address == radio_key_pkg::OFF_EVENTS;
  wire [6:0]  wr_frame = writedata[radio_key_pkg::FRM_WIDTH-1:0];
  wire        wr_eight = wr_frame[radio_key_pkg::FRM_EIGHT_BITS];
  wire        wr_two   = wr_frame[radio_key_pkg::FRM_TWO_STOP];
  wire [1:0]  wr_par   = wr_frame[radio_key_pkg::FRM_PARITY_LSB +: 2];
  wire        wr_none  = wr_par == radio_key_pkg::PARITY_NONE;
  // 7N1, 8O2, 8E2 and the unused parity code are refused
  wire        frame_bad = (!wr_eight && wr_none && !wr_two)
                        || (wr_eight && !wr_none && wr_two)
                        || (wr_par == 2'h3);
  wire        frame_wr  = wr_done & sel_frm;
  wire        reject_clr = wr_done & sel_sts & writedata[radio_key_pkg::STS_REJECT];

  // Status word and read mux
  logic [CW-1:0] count;
  wire [31:0] status_word = {{(24-CW){1'b0}}, count, 4'h0, frame_reject,
                             alarm_out, cts, tx_key};
  wire [31:0] read_mux = sel_mask ? alarm_event_mask
                       : sel_ctl  ? {26'h0, control}
                       : sel_frm  ? {25'h0, frame}
                       : sel_cts  ? {24'h0, cts_delay}
                       : sel_sts  ? status_word
                       : sel_evt  ? event_status
                       : 32'h0;

  // One wait state, then read data stands for the completing edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      readdata    <= read_mux;
    end
  end

  // Register writes; frame writes apply only to the main data port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_event_mask <= radio_key_pkg::RST_ALARM_MASK;
      control          <= radio_key_pkg::RST_CONTROL;
      frame            <= radio_key_pkg::RST_FRAME;
      cts_delay        <= radio_key_pkg::RST_CTS_DELAY;
    end else if (wr_done) begin
      if (sel_mask) alarm_event_mask <= writedata;
      if (sel_ctl) control <= writedata[radio_key_pkg::CTL_WIDTH-1:0];
      if (sel_frm && !frame_bad) frame <= wr_frame;
      if (sel_cts) cts_delay <= writedata[7:0];
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) frame_reject <= 1'b0;
    else frame_reject <= (frame_wr & frame_bad) | (frame_reject & ~reject_clr);
  end

  // Frame settings presented to the port serialiser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {port_rate_code, port_eight_bits, port_parity, port_two_stop, port_bit_cycles} <= 24'h0;
    end else begin
      port_rate_code  <= frame[radio_key_pkg::FRM_RATE_LSB +: 3];
      port_eight_bits <= frame[radio_key_pkg::FRM_EIGHT_BITS];
      port_parity     <= frame[radio_key_pkg::FRM_PARITY_LSB +: 2];
      port_two_stop   <= frame[radio_key_pkg::FRM_TWO_STOP];
      port_bit_cycles <= bit_cycles(frame[radio_key_pkg::FRM_RATE_LSB +: 3]);
    end
  end

  // Alarm: any masked-in event is major; drive with selected polarity
  wire [31:0] masked_events = event_status & alarm_event_mask;
  wire major_alarm = |masked_events;
  wire supply_fault = masked_events[radio_key_pkg::EVT_SIX_VOLT]
                    | masked_events[radio_key_pkg::EVT_INPUT_DC]
                    | masked_events[radio_key_pkg::EVT_TEMP];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) alarm_out <= 1'b0;
    else alarm_out <= ~(major_alarm ^ alarm_output_polarity);
  end

  // Millisecond tick for character hold and flush timers
  logic [23:0] ms_div;
  wire         ms_tick = ms_div == 24'(CYCLES_PER_MS - 1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ms_div <= 24'h0;
    else ms_div <= ms_tick ? 24'h0 : ms_div + 24'h1;
  end

  // CTS timing: terminal mode follows RTS, keyline mode follows radio data
  radio_key_pkg::cts_state_t cts_state, next_cts_state;
  logic [23:0] cts_wait;
  wire rts_rise   = rts_s & ~rts_prev;
  wire cts_start  = keyline_mode ? (radio_valid & radio_ready) : rts_rise;
  wire cts_hold   = keyline_mode ? (count != '0 || port_valid || radio_valid) : rts_s;
  wire delay_zero = cts_delay == 8'h00;
  always_comb begin
    next_cts_state = cts_state;
    unique case (cts_state)
      radio_key_pkg::CTS_IDLE:
        if (cts_start)
          next_cts_state = (delay_zero || keyline_mode) ? radio_key_pkg::CTS_ON
                                                        : radio_key_pkg::CTS_WAIT;
      radio_key_pkg::CTS_WAIT:
        if (!cts_hold) next_cts_state = radio_key_pkg::CTS_IDLE;
        else if (cts_wait == 24'h0) next_cts_state = radio_key_pkg::CTS_ON;
      radio_key_pkg::CTS_ON:
        if (!cts_hold) next_cts_state = radio_key_pkg::CTS_IDLE;
      default: next_cts_state = radio_key_pkg::CTS_IDLE;
    endcase
  end

  // Delay counter loaded on start, counts down in CTS_WAIT or keyline hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cts_wait <= 24'h0;
    else if (cts_state == radio_key_pkg::CTS_IDLE && cts_start)
      cts_wait <= delay_zero ? 24'h0 : ms_cycles(cts_delay) - 24'h1;
    else if (cts_wait != 24'h0) cts_wait <= cts_wait - 24'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cts_state <= radio_key_pkg::CTS_IDLE;
      cts       <= 1'b0;
    end else begin
      cts_state <= next_cts_state;
      cts       <= next_cts_state == radio_key_pkg::CTS_ON;
    end
  end

  // Keyline mode holds data back until the delay after CTS has run out
  wire release_ok = !keyline_mode || (cts_state == radio_key_pkg::CTS_ON && cts_wait == 24'h0);

  // Key-on-character hold timer restarted by each received character
  logic [7:0] char_ms;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) char_ms <= 8'h0;
    else if (char_received && key_on_character) char_ms <= 8'(radio_key_pkg::CHAR_HOLD_MS);
    else if (!key_on_character) char_ms <= 8'h0;
    else if (ms_tick && char_ms != 8'h0) char_ms <= char_ms - 8'h1;
  end

  // Transmitter key: OR of enabled sources, released when all are quiet
  wire rts_key  = rts_s & ~keyline_mode;
  wire next_key = continuous_keying
                | manual_key | ptt_s | rts_key
                | (char_ms != 8'h0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tx_key <= 1'b0;
    else tx_key <= next_key;
  end

  // Receive buffer; the transmit path never passes here
  logic [7:0]    store [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr;
  logic          draining;
  logic [7:0]    idle_ms;
  wire push      = radio_valid & radio_ready;
  wire can_load  = ~port_valid | port_ready;
  wire pop       = can_load & (count != '0) & release_ok
                 & (~receive_buffering | draining);
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);
  always_ff @(posedge clk) begin
    if (push) store[wr_ptr] <= radio_data;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {wr_ptr, rd_ptr, count} <= '0;
      radio_ready <= 1'b0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count       <= next_count;
      radio_ready <= next_count < CW'(DEPTH);
    end
  end

  // Seamless mode starts draining at the threshold, or after an idle spell
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {draining, idle_ms} <= 9'h0;
    end else begin
      if (push) idle_ms <= 8'h0;
      else if (ms_tick && idle_ms != 8'hff) idle_ms <= idle_ms + 8'h1;
      if (next_count == '0) draining <= 1'b0;
      else if (next_count >= CW'(THRESHOLD)
               || idle_ms >= 8'(radio_key_pkg::FLUSH_IDLE_MS)) draining <= 1'b1;
    end
  end

  // Output byte register toward the data port serialiser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {port_valid, port_data} <= 9'h0;
    end else if (can_load) begin
      port_valid <= pop;
      if (pop) port_data <= store[rd_ptr];
    end
  end

  // Checks
  sequence rts_rising_s;
    !keyline_mode && rts_s && !rts_prev && cts_state == radio_key_pkg::CTS_IDLE;
  endsequence
  sequence zero_delay_s;
    rts_rising_s ##0 delay_zero;
  endsequence

  alarm_polarity_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 alarm_out == ($past(alarm_output_polarity) ? $past(major_alarm) : !$past(major_alarm)))
    else $error("alarm output does not follow masked events and polarity");
  mask_suppress_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((event_status & alarm_event_mask) == 32'h0) |=> alarm_out == !$past(alarm_output_polarity))
    else $error("masked-out events raised the alarm");
  supply_alarm_a: assert property (@(posedge clk) disable iff (!rst_n)
    supply_fault |=> alarm_out == $past(alarm_output_polarity))
    else $error("supply fault did not raise the alarm");
  frame_reject_a: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_wr && frame_bad) |=> frame == $past(frame) && frame_reject)
    else $error("invalid frame setting was accepted");
  frame_accept_a: assert property (@(posedge clk) disable iff (!rst_n)
    (frame_wr && !frame_bad) |=> frame == $past(wr_frame)) else $error("valid frame not stored");
  zero_cts_a: assert property (@(posedge clk) disable iff (!rst_n)
    zero_delay_s |=> cts) else $error("cts late with zero delay");
  cts_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rts_rising_s ##0 !delay_zero) |=> !cts [*2]) else $error("cts rose before delay elapsed");
  continuous_key_a: assert property (@(posedge clk) disable iff (!rst_n)
    continuous_keying |=> tx_key) else $error("continuous keying not keyed");
  rts_key_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rts_s && !keyline_mode) |=> tx_key) else $error("rts did not key transmitter");
  key_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    !next_key |=> !tx_key) else $error("key held with no source");
  keyline_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (keyline_mode && cts_wait != 24'h0) |-> !pop) else $error("keyline data released early");
endmodule

// ===== hw/radio_key_pkg.sv
// Constants for the data-port keying, alarm and frame control block.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register slave.
package radio_key_pkg;
  // Register byte offsets
  localparam logic [4:0] OFF_ALARM_MASK = 5'h00;
  localparam logic [4:0] OFF_CONTROL    = 5'h04;
  localparam logic [4:0] OFF_FRAME      = 5'h08;
  localparam logic [4:0] OFF_CTS_DELAY  = 5'h0c;
  localparam logic [4:0] OFF_STATUS     = 5'h10;
  localparam logic [4:0] OFF_EVENTS     = 5'h14;

  // Control register fields
  localparam int CTL_POLARITY_HIGH = 0;
  localparam int CTL_BUFFERING     = 1;
  localparam int CTL_CONT_KEY      = 2;
  localparam int CTL_KEY_ON_CHAR   = 3;
  localparam int CTL_KEYLINE_MODE  = 4;
  localparam int CTL_MANUAL_KEY    = 5;
  localparam int CTL_WIDTH         = 6;

  // Frame register fields
  localparam int FRM_RATE_LSB   = 0;
  localparam int FRM_EIGHT_BITS = 3;
  localparam int FRM_PARITY_LSB = 4;
  localparam int FRM_TWO_STOP   = 6;
  localparam int FRM_WIDTH      = 7;

  // Status register fields
  localparam int STS_KEY     = 0;
  localparam int STS_CTS     = 1;
  localparam int STS_ALARM   = 2;
  localparam int STS_REJECT  = 3;
  localparam int STS_CNT_LSB = 8;

  // Reset values
  localparam logic [31:0] RST_ALARM_MASK = 32'hffff_ffff;
  localparam logic [5:0]  RST_CONTROL    = 6'h0b; // high polarity, buffering, key on char
  localparam logic [6:0]  RST_FRAME      = 7'h0e; // 19200, 8 bits, no parity, 1 stop
  localparam logic [7:0]  RST_CTS_DELAY  = 8'h00;

  // Parity codes
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ODD  = 2'h1;
  localparam logic [1:0] PARITY_EVEN = 2'h2;

  // Event positions for supply and temperature faults
  localparam int EVT_SIX_VOLT = 25;
  localparam int EVT_INPUT_DC = 26;
  localparam int EVT_TEMP     = 31;

  // Timing
  localparam int CLOCK_HZ      = 10000000;
  localparam int MS_PER_SECOND = 1000;
  localparam int CYCLES_PER_MS = CLOCK_HZ / MS_PER_SECOND;
  localparam int CHAR_HOLD_MS  = 2;
  localparam int FLUSH_IDLE_MS = 5;

  // Bit rates by rate code
  localparam int RATE_0 = 110;
  localparam int RATE_1 = 300;
  localparam int RATE_2 = 1200;
  localparam int RATE_3 = 2400;
  localparam int RATE_4 = 4800;
  localparam int RATE_5 = 9600;
  localparam int RATE_6 = 19200;
  localparam int RATE_7 = 38400;

  typedef enum logic [1:0] {
    CTS_IDLE = 2'b00,
    CTS_WAIT = 2'b01,
    CTS_ON   = 2'b11
  } cts_state_t;
endpackage

// ===== sim/radio_dte_model.sv
// Terminal-side model: RTS, push-to-talk, character strobe and port_ready.
// Assumes the bench changes the request inputs just after rising edges.
module radio_dte_model (
  input  wire logic clk,
  input  wire logic rts_req,
  input  wire logic ptt_req,
  input  wire logic char_req,
  input  wire logic stall,
  output logic      rts_pin,
  output logic      push_to_talk_input,
  output logic      char_received,
  output logic      port_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins idle low until asked for
  initial begin
    {rts_pin, push_to_talk_input, char_received, port_ready} = 4'h0;
  end
  // Pins follow the requests; ready drops at random while stalling
  always @(posedge clk) begin
    rts_pin <= rts_req;
    push_to_talk_input <= ptt_req;
    char_received <= char_req;
    port_ready <= !(stall && ($urandom_range(1) == 0));
  end
endmodule

// ===== sim/test_radio_key_alarm_control.sv
// Self-checking bench for radio_key_control with a terminal model.
// Assumes CYCLES_PER_MS shortened to 10 cycles.
module test_radio_key_alarm_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 10;
  logic        clk, reset_n, read, write, radio_valid, radio_ready, port_valid, port_ready;
  logic        rts_req, ptt_req, char_req, stall, rts_pin, push_to_talk_input, char_received;
  logic        cts, tx_key, alarm_out, waitrequest, port_eight_bits, port_two_stop;
  logic [1:0]  port_parity;
  logic [2:0]  port_rate_code;
  logic [4:0]  address;
  logic [7:0]  radio_data, port_data;
  logic [16:0] port_bit_cycles;
  logic [31:0] writedata, readdata, event_status, q, m, e;
  logic [7:0]  exp_q[$];
  int          errors, checks, cycles, n, c, rates[8], bad[4], dly[3];

  radio_key_control #(.CYCLES_PER_MS(MS)) i_dut (
    .clk, .reset_n, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .event_status, .rts_pin, .push_to_talk_input, .char_received, .radio_valid,
    .radio_data, .radio_ready, .port_valid, .port_data, .port_ready, .cts, .tx_key,
    .alarm_out, .port_rate_code, .port_eight_bits, .port_parity, .port_two_stop,
    .port_bit_cycles);
  radio_dte_model i_dte (.clk, .rts_req, .ptt_req, .char_req, .stall, .rts_pin,
    .push_to_talk_input, .char_received, .port_ready);

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Avalon master: hold request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d);
    @(posedge clk);
    radio_valid <= 1'b1;
    radio_data <= d;
    exp_q.push_back(d);
    do @(posedge clk); while (radio_ready !== 1'b1);
    radio_valid <= 1'b0;
    radio_data <= ~d;
  endtask
  task automatic wait_c(ref logic s, output int k);
    k = 0;
    while (s !== 1'b1 && k < 4000) begin
      @(posedge clk);
      k++;
    end
  endtask
  // One keying case, then all sources released
  task automatic key_case(input logic [31:0] ctl, input logic r, p, ch, x);
    bus(1, 5'h04, ctl);
    rts_req <= r;
    ptt_req <= p;
    char_req <= ch;
    @(posedge clk);
    char_req <= 1'b0;
    repeat (8) @(posedge clk);
    check(tx_key, x, "key on");
    bus(1, 5'h04, 32'h0);
    rts_req <= 1'b0;
    ptt_req <= 1'b0;
    repeat (30) @(posedge clk);
    check(tx_key, 0, "key off");
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Timeout and port stream comparison against the byte queue
  always @(posedge clk) begin
    cycles++;
    if (cycles > 30000) begin
      errors++;
      tally_and_finish();
    end
    if (port_valid === 1'b1 && port_ready === 1'b1) begin
      if (exp_q.size() == 0) check(port_data, 8'hxx, "extra byte");
      else check(port_data, exp_q.pop_front(), "port byte");
    end
  end

  initial begin
    {read, write, radio_valid, rts_req, ptt_req, char_req, stall, reset_n} = 8'h0;
    {address, radio_data, writedata, event_status} = '0;
    {errors, checks, cycles} = '0;
    rates = '{110, 300, 1200, 2400, 4800, 9600, 19200, 38400};
    bad = '{32'h06, 32'h5e, 32'h6e, 32'h3e};
    dly = '{0, 3, 255};
    void'($urandom(32'ha43b));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(0, 5'h00, 0);
    check(q, 32'hffff_ffff, "mask reset");
    bus(0, 5'h04, 0);
    check(q, 32'h0b, "control reset");
    bus(0, 5'h08, 0);
    check(q, 32'h0e, "frame reset");
    check(port_bit_cycles, 520, "reset rate");
    bus(0, 5'h18, 0);
    check(q, 0, "unmapped");
    // Alarm mask and polarity, fault events first
    for (n = 0; n < 6; n++) begin
      e = (n < 3) ? (32'h1 << ((n == 2) ? 31 : 25 + n)) : ($urandom & $urandom);
      m = (n == 2) ? ~e : ($urandom | ((n < 3) ? e : 32'h0));
      bus(1, 5'h00, m);
      bus(1, 5'h04, {31'h5, n[0]});
      event_status <= e;
      repeat (4) @(posedge clk);
      check(alarm_out, n[0] ? |(e & m) : !(|(e & m)), "alarm");
      bus(0, 5'h14, 0);
      check(q, e, "event word");
    end
    for (n = 0; n < 8; n++) begin
      bus(1, 5'h08, n | 8);
      repeat (3) @(posedge clk);
      check(port_bit_cycles, 10000000 / rates[n], "bit time");
    end
    bus(1, 5'h08, 32'h66);
    repeat (3) @(posedge clk);
    check({port_eight_bits, port_parity, port_two_stop}, 4'h5, "7E2");
    for (n = 0; n < 4; n++) begin
      bus(1, 5'h10, 32'h8);
      bus(0, 5'h10, 0);
      check(q[3], 0, "reject clear");
      bus(1, 5'h08, bad[n]);
      bus(0, 5'h08, 0);
      check(q, 32'h66, "refused frame");
      bus(0, 5'h10, 0);
      check(q[3], 1, "reject flag");
    end
    key_case(32'h04, 0, 0, 0, 1);
    key_case(32'h00, 0, 0, 1, 0);
    key_case(32'h08, 0, 0, 1, 1);
    key_case(32'h00, 1, 0, 0, 1);
    key_case(32'h00, 0, 1, 0, 1);
    key_case(32'h20, 0, 0, 0, 1);
    key_case(32'h10, 1, 0, 0, 0);
    // Terminal mode CTS delay at 0, 3 and 255 ms
    bus(1, 5'h04, 32'h0b);
    for (n = 0; n < 3; n++) begin
      bus(1, 5'h0c, dly[n]);
      rts_req <= 1'b1;
      wait_c(cts, c);
      check(c >= dly[n] * MS + 2 && c <= dly[n] * MS + 8, 1, "cts delay");
      rts_req <= 1'b0;
      repeat (8) @(posedge clk);
      check(cts, 0, "cts drop");
    end
    // Keyline mode: data held back for the delay after CTS
    bus(1, 5'h0c, 2);
    bus(1, 5'h04, 32'h10);
    rts_req <= 1'b1;
    repeat (8) @(posedge clk);
    check(cts, 0, "rts ignored");
    send($urandom);
    @(posedge clk);
    check(cts, 1, "keyline cts");
    wait_c(port_valid, c);
    check(c >= 2 * MS - 2, 1, "keyline hold");
    rts_req <= 1'b0;
    stall <= 1'b1;
    for (n = 0; n < 20; n++) send($urandom);
    bus(1, 5'h04, 32'h0b);
    for (n = 0; n < 12; n++) send($urandom);
    repeat (300) @(posedge clk);
    check(exp_q.size(), 0, "drained");
    tally_and_finish();
  end
endmodule
